// ---- design/utr_core.sv ----
/*
 * Asynchronous serial transmitter/receiver with an AHB-Lite register slave.
 * Assumes synchronous pin inputs, one 250 MHz clock and an external pad that
 * combines tx_out/tx_oe; the rx line is sampled directly on hclk.
 */
// What this block does
// - Enabled async mode drives TX, listens RX, idles high
// - Global disable releases pins, empties receive buffer
// - Disable clears enables and errors, sets idle flags
// - Disable keeps divisor and other control bits except break
// - Disable mid-transfer aborts everything at once
// - Word 8/9 bits, parity on/odd/even, stop count
// - Two stop bits transmit only; receiver checks one
// - Nine-bit transmit MSB comes from transmit_bit_eight, or is parity when parity is on
// - Shifter reloads only after previous stop bit
// - Start needs enable, data, shift clock; either order
// - Transmit enable cleared aborts and resets transmitter
// - Words shift out least significant bit first
// - Data writes ignored while transmit-empty is zero
// - Transmit-empty flags free holding register, gated interrupt
// - Idle write loads shifter; busy write is held
// - Transmit-idle set after stop or break frame
// - Break held beyond divisor+1 cycles sends break
// - Breaks repeat, no interrupt, then stop bits
// - Nine-bit receive MSB lands in receive_bit_eight
// - Recovery at 16x, word stored after stop
// - Each bit is majority of three samples
// - Baud is clock over 64(N+1) or 16(N+1)
// - Receive buffer holds two words
// - Zero at stop position sets framing error, unless the buffer is full
`timescale 1ns/10ps
module utr_core import utr_pkg::*; #(
    parameter int BRK_BITS = BREAK_BITS
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Serial pins and mode strap
    input wire logic async_mode_select,
    input wire logic rx_in,
    output logic tx_out,
    output logic tx_oe,
    output logic rx_ie,
    // Transmit-empty interrupt request
    output logic tx_irq
);
    // Break length must fit the 4-bit bit counter
    if (BRK_BITS < 13 || BRK_BITS > 16) begin : g_brk_check
        $error("BRK_BITS out of range");
    end
    localparam logic [3:0] BRK_LAST = 4'(BRK_BITS - 1);

    // Complete block state, registered as one word
    typedef struct packed {
        logic [7:0] ctl1;
        logic [7:0] ctl2;
        logic [7:0] div;
        logic dp_valid;
        logic dp_write;
        logic [7:0] dp_addr;
        logic [31:0] rdata;
        logic stat_arm;
        logic txe;
        logic tidle;
        utr_tx_t tx_st;
        logic [8:0] tx_sh;
        logic [3:0] tx_bits;
        logic [3:0] tx_sub;
        logic tx_pend;
        logic tx_isbrk;
        logic [8:0] hold;
        logic hold_full;
        logic tx_line;
        logic [8:0] brk_cnt;
        logic brk_arm;
        logic [9:0] pre;
        utr_rx_t rx_st;
        logic [8:0] rx_sh;
        logic [3:0] rx_bits;
        logic [3:0] rx_sub;
        logic rx_prev;
        logic [1:0] smp;
        logic rx_nz;
        logic [1:0][8:0] fifo;
        logic [1:0] fcnt;
        logic ovr;
        logic fe;
        logic pe;
        logic nf;
    } utr_state_t;

    localparam utr_state_t ST_RST = '{ctl1: CTRL1_RST, ctl2: CTRL2_RST, div: DIV_RST, txe: 1'h1,
        tidle: 1'h1, tx_st: TX_IDLE, tx_line: 1'h1, rx_st: RX_IDLE, rx_prev: 1'h1, default: '0};

    utr_state_t s;
    utr_state_t n;

    // Word offset match; byte lanes and size are ignored, whole words only
    function automatic logic is_at(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // Builds the transmitted word: 9th bit and parity placed in the MSB slot
    function automatic logic [8:0] frame_word(input logic [8:0] w, input logic wl, input logic pen,
                                              input logic podd);
        logic [8:0] r;
        r = w;
        if (!wl) begin
            r[8] = 1'h0;
        end
        if (pen && wl) begin
            r[8] = (^w[7:0]) ^ podd;
        end else if (pen) begin
            r[7] = (^w[6:0]) ^ podd;
        end
        return r;
    endfunction

    // Decoded enables and shared timing strobes
    logic gen;
    logic tx_en;
    logic rx_act;
    logic [3:0] last_bit;
    logic [9:0] pre_lim;
    logic tick16;
    logic btick;
    logic ap_take;
    logic dp_wr_data;
    logic maj;
    logic noisy;
    logic [8:0] rx_word;
    logic rx_perr;

    assign gen = s.ctl1[C1_GEN];
    assign tx_en = gen & s.ctl2[C2_TXEN] & async_mode_select;
    assign rx_act = gen & s.ctl2[C2_RXEN] & async_mode_select;
    assign last_bit = s.ctl1[C1_WLEN] ? LAST9 : LAST8;
    // Low speed divides by four more, giving 64(N+1) per bit
    assign pre_lim = s.ctl2[C2_HSB] ? {2'h0, s.div} : {s.div, 2'h3};
    assign tick16 = gen & (s.pre == 10'h000);
    assign btick = tick16 & (s.tx_sub == SUB_LAST);
    assign ap_take = hsel & hready & htrans[1];
    assign dp_wr_data = s.dp_valid & s.dp_write & is_at(s.dp_addr, OFF_DATA);
    // Majority of samples A, B and the live C sample
    assign maj = (s.smp[1] & s.smp[0]) | (s.smp[1] & rx_in) | (s.smp[0] & rx_in);
    assign noisy = !((s.smp[1] == s.smp[0]) && (s.smp[0] == rx_in));
    // An 8-bit word arrives in the top eight bits of the shifter
    assign rx_word = s.ctl1[C1_WLEN] ? s.rx_sh : {1'h0, s.rx_sh[8:1]};
    assign rx_perr = s.ctl1[C1_PEN] & ((^rx_word) != s.ctl1[C1_PODD]);

    // Next-state logic for bus, transmitter and receiver
    always_comb begin
        n = s;
        // Baud prescaler produces the 16x tick
        n.pre = (tick16 || !gen) ? pre_lim : s.pre - 10'h001;
        if (tick16) begin
            n.tx_sub = s.tx_sub + 4'h1;
        end
        n.rx_prev = rx_in;
        // Address phase: capture for writes, answer reads now so hrdata is a flop
        n.dp_valid = ap_take;
        n.dp_write = hwrite;
        n.dp_addr = haddr[7:0];
        if (ap_take && !hwrite) begin
            n.rdata = 32'h0000_0000;
            if (is_at(haddr[7:0], OFF_CTRL1)) begin
                n.rdata[7:0] = {s.ctl1[7:2], s.fifo[0][8], s.ctl1[C1_TX8]};
            end else if (is_at(haddr[7:0], OFF_CTRL2)) begin
                n.rdata[7:0] = s.ctl2;
            end else if (is_at(haddr[7:0], OFF_DIV)) begin
                n.rdata[7:0] = s.div;
            end else if (is_at(haddr[7:0], OFF_STAT)) begin
                n.rdata[7:0] = {s.pe, s.nf, s.fe, s.ovr, s.rx_st == RX_IDLE, s.fcnt != 2'h0, s.tidle, s.txe};
                n.stat_arm = 1'h1;
            end else if (is_at(haddr[7:0], OFF_DATA)) begin
                n.rdata[7:0] = s.fifo[0][7:0];
                if (s.fcnt != 2'h0) begin
                    n.fifo[0] = s.fifo[1];
                    n.fcnt = s.fcnt - 2'h1;
                end
                // Status read then data read clears the receive error flags
                if (s.stat_arm) begin
                    n.ovr = 1'h0;
                    n.fe = 1'h0;
                    n.pe = 1'h0;
                    n.nf = 1'h0;
                    n.stat_arm = 1'h0;
                end
            end
        end
        // Data phase writes
        if (s.dp_valid && s.dp_write) begin
            if (is_at(s.dp_addr, OFF_CTRL1)) begin
                n.ctl1 = {hwdata[7:2], 1'h0, hwdata[0]};
            end else if (is_at(s.dp_addr, OFF_CTRL2)) begin
                n.ctl2 = hwdata[7:0];
            end else if (is_at(s.dp_addr, OFF_DIV)) begin
                n.div = hwdata[7:0];
            end
        end
        // Data write is dropped while the holding register is still full
        if (dp_wr_data && s.txe) begin
            if (s.stat_arm) begin
                n.tidle = 1'h0;
                n.stat_arm = 1'h0;
            end
            if (tx_en && s.tx_st == TX_IDLE && !s.tx_pend && !s.hold_full) begin
                // Straight into the shifter; holding register stays free
                n.tx_sh = frame_word({s.ctl1[C1_TX8], hwdata[7:0]}, s.ctl1[C1_WLEN], s.ctl1[C1_PEN],
                                     s.ctl1[C1_PODD]);
                n.tx_pend = 1'h1;
            end else begin
                n.hold = frame_word({s.ctl1[C1_TX8], hwdata[7:0]}, s.ctl1[C1_WLEN], s.ctl1[C1_PEN],
                                    s.ctl1[C1_PODD]);
                n.hold_full = 1'h1;
                n.txe = 1'h0;
            end
        end
        // Break request must be held past divisor+1 cycles while idle
        if (gen && s.ctl1[C1_BRK] && s.tidle) begin
            if (s.brk_cnt > {1'h0, s.div}) begin
                n.brk_arm = 1'h1;
            end else begin
                n.brk_cnt = s.brk_cnt + 9'h001;
            end
        end else if (!s.ctl1[C1_BRK]) begin
            n.brk_cnt = 9'h000;
            n.brk_arm = 1'h0;
        end
        // Transmit sequencer, one step per bit time
        if (btick) begin
            case (s.tx_st)
                TX_START: begin
                    n.tx_bits = 4'h0;
                    n.tx_st = s.tx_isbrk ? TX_BREAK : TX_DATA;
                end
                TX_DATA: begin
                    n.tx_sh = {1'h0, s.tx_sh[8:1]};
                    n.tx_bits = s.tx_bits + 4'h1;
                    if (s.tx_bits == last_bit) begin
                        n.tx_bits = 4'h0;
                        n.tx_st = TX_STOP;
                    end
                end
                TX_BREAK: begin
                    n.tx_bits = s.tx_bits + 4'h1;
                    // Another break character follows while the request stays high
                    if (s.tx_bits == BRK_LAST) begin
                        n.tx_bits = 4'h0;
                        if (!s.ctl1[C1_BRK]) begin
                            n.tx_st = TX_STOP;
                        end
                    end
                end
                TX_STOP: begin
                    if (s.tx_bits == {3'h0, s.ctl1[C1_STOP2]}) begin
                        n.tx_st = TX_IDLE;
                        n.tidle = 1'h1;
                        n.tx_isbrk = 1'h0;
                    end else begin
                        n.tx_bits = s.tx_bits + 4'h1;
                    end
                end
                default: begin
                end
            endcase
        end
        // Dropping transmit enable kills the frame in progress, keeps held data
        if (!tx_en && s.tx_st != TX_IDLE) begin
            n.tx_st = TX_IDLE;
            n.tx_isbrk = 1'h0;
            n.tx_bits = 4'h0;
        end
        // Launch a frame from idle at a bit boundary; the stop end joins here too
        if (n.tx_st == TX_IDLE && btick && tx_en) begin
            if (n.brk_arm) begin
                n.tx_isbrk = 1'h1;
                n.brk_arm = 1'h0;
                n.brk_cnt = 9'h000;
                n.tx_st = TX_START;
            end else if (n.tx_pend) begin
                n.tx_pend = 1'h0;
                n.tx_st = TX_START;
            end else if (n.hold_full) begin
                n.tx_sh = n.hold;
                n.hold_full = 1'h0;
                n.txe = 1'h1;
                n.tx_st = TX_START;
            end
        end
        // Receiver: edge-triggered start, three samples mid-bit
        if (!rx_act) begin
            n.rx_st = RX_IDLE;
        end else if (s.rx_st == RX_IDLE) begin
            if (s.rx_prev && !rx_in) begin
                n.rx_st = RX_START;
                n.rx_sub = 4'h0;
                n.rx_bits = 4'h0;
                n.rx_nz = 1'h0;
            end
        end else if (tick16) begin
            n.rx_sub = s.rx_sub + 4'h1;
            if (s.rx_sub == SMP_A || s.rx_sub == SMP_B) begin
                n.smp = {s.smp[0], rx_in};
            end
            if (s.rx_sub == SMP_C) begin
                n.rx_nz = s.rx_nz | noisy;
                case (s.rx_st)
                    RX_START: begin
                        // A start that reads high was a glitch
                        n.rx_st = maj ? RX_IDLE : RX_DATA;
                    end
                    RX_DATA: begin
                        n.rx_sh = {maj, s.rx_sh[8:1]};
                        n.rx_bits = s.rx_bits + 4'h1;
                        if (s.rx_bits == last_bit) begin
                            n.rx_st = RX_STOP;
                        end
                    end
                    RX_STOP: begin
                        // Single stop bit regardless of the transmit stop setting
                        n.rx_st = RX_IDLE;
                        if (n.fcnt == 2'h2) begin
                            n.ovr = 1'h1;
                        end else begin
                            n.fifo[n.fcnt[0]] = rx_word;
                            n.fcnt = n.fcnt + 2'h1;
                            n.fe = n.fe | !maj;
                            n.pe = n.pe | rx_perr;
                            n.nf = n.nf | s.rx_nz | noisy;
                        end
                    end
                    default: begin
                        n.rx_st = RX_IDLE;
                    end
                endcase
            end
        end
        // Global disable: abort all, flush buffer, keep configuration except the enables and break
        if (!n.ctl1[C1_GEN]) begin
            n.ctl2[C2_TXEN] = 1'h0;
            n.ctl2[C2_RXEN] = 1'h0;
            n.ctl1[C1_BRK] = 1'h0;
            n.fcnt = 2'h0;
            n.ovr = 1'h0;
            n.fe = 1'h0;
            n.pe = 1'h0;
            n.nf = 1'h0;
            n.txe = 1'h1;
            n.tidle = 1'h1;
            n.tx_st = TX_IDLE;
            n.rx_st = RX_IDLE;
            n.tx_pend = 1'h0;
            n.hold_full = 1'h0;
            n.tx_isbrk = 1'h0;
            n.brk_arm = 1'h0;
            n.brk_cnt = 9'h000;
        end
        // Line is high except in start, break and zero data bits
        n.tx_line = (n.tx_st == TX_DATA) ? n.tx_sh[0] : !(n.tx_st == TX_START || n.tx_st == TX_BREAK);
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= ST_RST;
        end else begin
            s <= n;
        end
    end

    // Outputs; pins are released whenever the unit or direction is off
    assign hrdata = s.rdata;
    assign hreadyout = 1'h1;
    assign hresp = 1'h0;
    assign tx_out = s.tx_line;
    assign tx_oe = tx_en;
    assign rx_ie = rx_act;
    // No interrupt while break characters are going out
    assign tx_irq = gen & s.txe & s.ctl2[C2_TEIE] & !s.tx_isbrk;

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_tx_idle_high;
        (tx_oe && s.tx_st == TX_IDLE) |-> tx_out;
    endproperty
    a_tx_idle_high: assert property (p_tx_idle_high) else $error("tx low while idle");
    property p_disable_clears;
        !gen |-> (s.txe && s.tidle && s.fcnt == 2'h0 && !s.ctl2[C2_TXEN] && !s.ovr && s.rx_st == RX_IDLE);
    endproperty
    a_disable_clears: assert property (p_disable_clears) else $error("disable left state");
    property p_disable_keeps;
        $fell(gen) |-> (s.div == $past(s.div) && s.ctl2[C2_HSB] == $past(s.ctl2[C2_HSB]));
    endproperty
    a_disable_keeps: assert property (p_disable_keeps) else $error("disable changed config");
    property p_txen_abort;
        !tx_en |=> (s.tx_st == TX_IDLE && tx_out);
    endproperty
    a_txen_abort: assert property (p_txen_abort) else $error("transmit not reset");
    property p_write_ignored;
        (dp_wr_data && !s.txe) |=> $stable(s.hold);
    endproperty
    a_write_ignored: assert property (p_write_ignored) else $error("write taken while full");
    property p_stop_idle;
        (btick && tx_en && s.tx_st == TX_STOP && s.tx_bits == {3'h0, s.ctl1[C1_STOP2]}) |=> s.tidle;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("idle flag not set");
    property p_lsb_first;
        (btick && tx_en && s.tx_st == TX_DATA && s.tx_bits != last_bit && !s.dp_valid)
            |=> (tx_out == $past(s.tx_sh[1]));
    endproperty
    a_lsb_first: assert property (p_lsb_first) else $error("wrong bit order");
    property p_fifo_bound;
        s.fcnt <= 2'h2;
    endproperty
    a_fifo_bound: assert property (p_fifo_bound) else $error("receive buffer overfilled");
    property p_frame_err;
        (rx_act && tick16 && s.rx_st == RX_STOP && s.rx_sub == SMP_C && !maj && !s.dp_valid) |=> (s.fe || s.ovr);
    endproperty
    a_frame_err: assert property (p_frame_err) else $error("framing error missed");
    property p_baud_reload;
        tick16 |=> (s.pre == $past(pre_lim));
    endproperty
    a_baud_reload: assert property (p_baud_reload) else $error("prescaler reload wrong");

    c_tx_start: cover property (btick && tx_en && s.tx_st == TX_START);
    c_rx_push: cover property (rx_act && tick16 && s.rx_st == RX_STOP && s.rx_sub == SMP_C);
    c_overrun: cover property ($rose(s.ovr));
    c_break: cover property (s.tx_st == TX_BREAK);
endmodule

// ---- design/utr_pkg.sv ----
/*
 * Shared constants for the asynchronous serial core: register byte offsets,
 * field positions, reset values, oversampling points and state encodings.
 * Assumes a 32-bit AHB-Lite register bus with one aligned word per register.
 */
package utr_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL1 = 8'h00;
    localparam logic [7:0] OFF_CTRL2 = 8'h04;
    localparam logic [7:0] OFF_DIV = 8'h08;
    localparam logic [7:0] OFF_DATA = 8'h0C;
    localparam logic [7:0] OFF_STAT = 8'h10;
    // serial_control_one fields
    localparam int C1_GEN = 7;
    localparam int C1_WLEN = 6;
    localparam int C1_PEN = 5;
    localparam int C1_PODD = 4;
    localparam int C1_STOP2 = 3;
    localparam int C1_BRK = 2;
    localparam int C1_RX8 = 1;
    localparam int C1_TX8 = 0;
    // serial_control_two fields
    localparam int C2_TXEN = 7;
    localparam int C2_RXEN = 6;
    localparam int C2_HSB = 5;
    localparam int C2_ADDR = 4;
    localparam int C2_TEIE = 0;
    // Reset values
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [7:0] CTRL2_RST = 8'h00;
    localparam logic [7:0] DIV_RST = 8'h00;
    // Oversampling: last sub-slot of a bit and the three majority sample points
    localparam logic [3:0] SUB_LAST = 4'hF;
    localparam logic [3:0] SMP_A = 4'h7;
    localparam logic [3:0] SMP_B = 4'h8;
    localparam logic [3:0] SMP_C = 4'h9;
    // Last data-bit index for 8- and 9-bit words
    localparam logic [3:0] LAST8 = 4'h7;
    localparam logic [3:0] LAST9 = 4'h8;
    // Zero bits in one break character
    localparam int BREAK_BITS = 13;
    // Transmit and receive state encodings, one-hot
    typedef enum logic [4:0] {
        TX_IDLE = 5'h01,
        TX_START = 5'h02,
        TX_DATA = 5'h04,
        TX_BREAK = 5'h08,
        TX_STOP = 5'h10
    } utr_tx_t;
    typedef enum logic [3:0] {
        RX_IDLE = 4'h1,
        RX_START = 4'h2,
        RX_DATA = 4'h4,
        RX_STOP = 4'h8
    } utr_rx_t;
endpackage

// ---- verification/tb_utr_core.sv ----
/*
 * Self-checking bench for utr_core: AHB-Lite register tasks and a remote partner.
 * Assumes divisor 0: one bit lasts 16 clocks, 64 in the single low-speed test.
 */
`timescale 1ns/10ps
module tb_utr_core import utr_pkg::*; ();
    logic hclk = 1'b0; // Clock and reset
    logic hresetn = 1'b0;
    logic hsel = 1'b0; // Bus request
    logic hwrite = 1'b0;
    logic [31:0] haddr = '0;
    logic [31:0] hwdata = '0;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hrdata; // Bus answer
    logic [31:0] rd_val;
    logic hreadyout;
    logic hresp;
    logic mode = 1'b1; // Async mode strap, on except during the single strap-off check
    logic rx_in; // Serial pins
    logic tx_out;
    logic tx_oe;
    logic rx_ie;
    logic tx_irq;
    int errors = 0;
    int samples_checked = 0;
    // Frame formats: control word, data, captured length, expected word
    logic [7:0] fmt_cfg [4] = '{8'hC1, 8'hA0, 8'hB0, 8'hC8};
    logic [7:0] fmt_dat [4] = '{8'h5A, 8'h07, 8'h07, 8'hFF};
    logic [8:0] fmt_exp [4] = '{9'h15A, 9'h087, 9'h007, 9'h0FF};
    int fmt_len [4] = '{9, 8, 8, 9};
    logic [7:0] rx_dat [3] = '{8'h11, 8'h22, 8'h33};
    // 250 MHz clock
    always #2 hclk = ~hclk;
    utr_core utr_core_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .async_mode_select(mode), .rx_in(rx_in), .tx_out(tx_out),
        .tx_oe(tx_oe), .rx_ie(rx_ie), .tx_irq(tx_irq));
    utr_remote utr_remote_inst (.hclk(hclk), .tx_line(tx_out), .rx_line(rx_in));
    // One single transfer: address phase, then data phase; read data taken at its end
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd_val = hrdata;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 8'h00);
        chk($sformatf("register %h", a), exp, rd_val);
        chk("response", 32'h0, {31'h0, hresp});
    endtask
    // Wait, bounded, for one captured word; a missing word becomes unknown
    task automatic tx_chk(input logic [8:0] exp);
        int k = 0;
        while (utr_remote_inst.got_q.size() == 0 && k < 4000) begin
            @(posedge hclk);
            k++;
        end
        if (utr_remote_inst.got_q.size() == 0) begin
            utr_remote_inst.got_q.push_back('x);
        end
        chk("tx word", {23'h0, exp}, {23'h0, utr_remote_inst.got_q.pop_front()});
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic note(input string s);
        $display("test %s finished, %0d mismatches so far", s, errors);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Watchdog: the whole sequence needs well under this span
    initial begin
        repeat (30000) @(posedge hclk);
        errors++;
        test_done();
    end
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        rd(OFF_STAT, 32'h0B);
        chk("idle line", 32'h1, {31'h0, tx_out});
        wr(OFF_DIV, 8'h00);
        // Enables in control_two are held clear while the unit is off, so enable first
        wr(OFF_CTRL1, 8'h80);
        wr(OFF_CTRL2, 8'hE0);
        idle(1);
        chk("pin enables", 32'h3, {30'h0, tx_oe, rx_ie});
        mode <= 1'b0;
        idle(1);
        chk("mode strap off", 32'h0, {30'h0, tx_oe, rx_ie});
        mode <= 1'b1;
        // Direct load, one held word, one refused word
        rd(OFF_STAT, 32'h0B);
        wr(OFF_DATA, 8'hA5);
        wr(OFF_DATA, 8'h3C);
        rd(OFF_STAT, 32'h08);
        wr(OFF_DATA, 8'h5A);
        tx_chk(9'h0A5);
        tx_chk(9'h03C);
        idle(400);
        chk("extra words", 32'h0, 32'(utr_remote_inst.got_q.size()));
        rd(OFF_STAT, 32'h0B);
        note("transmit");
        foreach (fmt_cfg[i]) begin
            idle(40);
            wr(OFF_CTRL1, fmt_cfg[i]);
            utr_remote_inst.nbits = fmt_len[i];
            rd(OFF_STAT, 32'h0B);
            wr(OFF_DATA, fmt_dat[i]);
            tx_chk(fmt_exp[i]);
        end
        // Low-speed baud: 64 clocks per bit
        idle(40);
        wr(OFF_CTRL1, 8'h80);
        wr(OFF_CTRL2, 8'hC0);
        utr_remote_inst.nbits = 8;
        utr_remote_inst.bit_clks = 64;
        rd(OFF_STAT, 32'h0B);
        wr(OFF_DATA, 8'hC3);
        tx_chk(9'h0C3);
        wr(OFF_CTRL2, 8'hE0);
        utr_remote_inst.bit_clks = 16;
        note("formats");
        idle(40);
        wr(OFF_CTRL1, 8'h80);
        utr_remote_inst.send(9'h0C3, 8, 1'b1);
        rd(OFF_STAT, 32'h0F);
        rd(OFF_DATA, 32'hC3);
        wr(OFF_CTRL1, 8'hC0);
        utr_remote_inst.send(9'h1A5, 9, 1'b1);
        rd(OFF_CTRL1, 32'hC2);
        rd(OFF_DATA, 32'hA5);
        wr(OFF_CTRL1, 8'h80);
        foreach (rx_dat[i]) begin
            utr_remote_inst.send({1'b0, rx_dat[i]}, 8, 1'b1);
        end
        rd(OFF_STAT, 32'h1F);
        rd(OFF_DATA, 32'h11);
        rd(OFF_DATA, 32'h22);
        utr_remote_inst.send(9'h055, 8, 1'b0);
        rd(OFF_STAT, 32'h2F);
        rd(OFF_DATA, 32'h55);
        note("receive");
        // Disable with a word in the buffer and a frame on the line
        utr_remote_inst.send(9'h077, 8, 1'b1);
        wr(OFF_DATA, 8'h0F);
        idle(40);
        wr(OFF_CTRL1, 8'h00);
        idle(1);
        chk("pins off", 32'h1, {29'h0, tx_oe, rx_ie, tx_out});
        rd(OFF_STAT, 32'h0B);
        rd(OFF_CTRL2, 32'h20);
        idle(200);
        utr_remote_inst.got_q.delete();
        // Data first, transmit enable afterwards
        wr(OFF_CTRL1, 8'h80);
        rd(OFF_STAT, 32'h0B);
        wr(OFF_DATA, 8'h96);
        idle(200);
        chk("early words", 32'h0, 32'(utr_remote_inst.got_q.size()));
        wr(OFF_CTRL2, 8'hE1);
        tx_chk(9'h096);
        chk("empty irq", 32'h1, {31'h0, tx_irq});
        note("disable");
        idle(40);
        wr(OFF_CTRL1, 8'h84);
        idle(300);
        chk("break line", 32'h0, {30'h0, tx_out, tx_irq});
        wr(OFF_CTRL1, 8'h80);
        idle(300);
        chk("after break", 32'h1, {31'h0, tx_out});
        note("break");
        test_done();
    end
endmodule

// ---- verification/utr_remote.sv ----
/*
 * Remote serial partner: captures frames sent by the core, sends frames to it.
 * Assumes one bit lasts bit_clks hclk cycles, set by the bench, and both lines idle high.
 */
`timescale 1ns/10ps
module utr_remote #(
    parameter int BIT_CLKS = 16
) (
    // Clock
    input wire logic hclk,
    // Serial lines
    input wire logic tx_line,
    output logic rx_line
);
    int nbits = 8; // Word length to capture
    int bit_clks = BIT_CLKS; // Bit length; changed only between frames
    logic [8:0] got_q[$]; // Words whose stop bit was high
    initial rx_line = 1'b1;
    // Sample bit centres; a frame with a low stop is dropped so the bench sees it missing
    always begin : capture
        logic [8:0] w;
        @(negedge tx_line);
        w = '0;
        repeat (bit_clks / 2) @(posedge hclk);
        for (int i = 0; i < nbits; i++) begin
            repeat (bit_clks) @(posedge hclk);
            w[i] = tx_line;
        end
        repeat (bit_clks) @(posedge hclk);
        if (tx_line === 1'b1) begin
            got_q.push_back(w);
        end
    end
    // Start bit, LSB first, a single stop of chosen level, then one idle bit
    task automatic send(input logic [8:0] w, input int n, input logic stop);
        @(posedge hclk) rx_line <= 1'b0;
        for (int i = 0; i <= n; i++) begin
            repeat (bit_clks) @(posedge hclk);
            rx_line <= (i == n) ? stop : w[i];
        end
        repeat (bit_clks) @(posedge hclk);
        rx_line <= 1'b1;
        repeat (bit_clks) @(posedge hclk);
    endtask
endmodule
